// File: rtl/sitpu_pkg.sv
// Package of constants for the sensor I2C target with power-up wait.
package sitpu_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h62;
  localparam int CLK_HZ = 20000000;
  localparam int POWER_UP_MS = 1000;
  localparam int REINIT_MS = 1000;
  localparam int SCL_MAX_KHZ = 100;
  // Longest times round down to whole cycles.
  localparam longint POWER_UP_CYC = (longint'(POWER_UP_MS) * CLK_HZ) / 1000;
  localparam longint REINIT_CYC = (longint'(REINIT_MS) * CLK_HZ) / 1000;
  localparam int WAIT_W = 26;
  localparam logic [15:0] CMD_REINIT = 16'h3646;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam int BIT_LAST = 7;
  typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK, ST_SKIP} sitpu_state_t;
endpackage

// File: rtl/sitpu_target.sv
// I2C target front end of the sensor with address match, command capture and readiness gating.
//
// Functional notes
// - Commands are single 16-bit codes.
// - Idle reached at most 1000 ms after power-up.
// - Idle state accepts commands.
// - Soft reset completes within 1000 ms.
// - Standard mode, SCL static up to 100 kHz.
// - START and STOP frame every transfer.
// - Words MSB first, then 8-bit CRC.
`timescale 1ns/10ps
module sitpu_target #(
  parameter logic [25:0] POWER_UP_CYCLES = 26'(sitpu_pkg::POWER_UP_CYC),
  parameter logic [25:0] REINIT_CYCLES = 26'(sitpu_pkg::REINIT_CYC)
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [15:0] txWord,
  output logic [15:0] cmdCode_r,
  output logic cmdValid_r,
  output logic [15:0] argWord_r,
  output logic argValid_r,
  output logic crcError_r,
  output logic ready_r,
  output logic busy_r
);
  sitpu_pkg::sitpu_state_t state_r;
  logic sclQ_r, sdaQ_r;
  logic [7:0] shift_r;
  logic [3:0] bitCnt_r;
  logic isRead_r;
  logic [1:0] byteIdx_r;
  logic wordCount_r;
  logic [15:0] word_r;
  logic [7:0] crc_r;
  logic ackBit_r;
  logic timerReady;
  logic reinitReq_r;

  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ sitpu_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  wire sclRise = sclIn && !sclQ_r;
  wire sclFall = !sclIn && sclQ_r;
  // Read stream order is MSB, LSB, checksum, then the same word again.
  wire [7:0] txNext = (byteIdx_r == 2'h0) ? word_r[7:0] : (byteIdx_r == 2'h1) ? crc_r : word_r[15:8];
  wire startCond = sclIn && sclQ_r && sdaQ_r && !sdaIn;
  wire stopCond = sclIn && sclQ_r && !sdaQ_r && sdaIn;

  sitpu_wait_timer #(
    .POWER_UP_CYCLES(POWER_UP_CYCLES),
    .REINIT_CYCLES(REINIT_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .startReinit(reinitReq_r),
    .ready(timerReady)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclQ_r <= 1'b1;
      sdaQ_r <= 1'b1;
      ready_r <= 1'b0;
    end else begin
      sclQ_r <= sclIn;
      sdaQ_r <= sdaIn;
      ready_r <= timerReady;
    end
  end

  // Oversampled bus: SCL may stop at any point, no timeout is applied.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= sitpu_pkg::ST_IDLE;
      shift_r <= 8'h00;
      bitCnt_r <= 4'h0;
      isRead_r <= 1'b0;
      byteIdx_r <= 2'h0;
      wordCount_r <= 1'b0;
      word_r <= 16'h0000;
      crc_r <= sitpu_pkg::CRC_INIT;
      ackBit_r <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      cmdCode_r <= 16'h0000;
      cmdValid_r <= 1'b0;
      argWord_r <= 16'h0000;
      argValid_r <= 1'b0;
      crcError_r <= 1'b0;
      busy_r <= 1'b0;
      reinitReq_r <= 1'b0;
    end else begin
      cmdValid_r <= 1'b0;
      argValid_r <= 1'b0;
      reinitReq_r <= 1'b0;
      busy_r <= !timerReady;
      if (startCond) begin
        state_r <= sitpu_pkg::ST_ADDR;
        bitCnt_r <= 4'h0;
        byteIdx_r <= 2'h0;
        wordCount_r <= 1'b0;
        crc_r <= sitpu_pkg::CRC_INIT;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        state_r <= sitpu_pkg::ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state_r)
          sitpu_pkg::ST_IDLE: begin
            sdaOe <= 1'b0;
          end
          sitpu_pkg::ST_ADDR, sitpu_pkg::ST_RX: begin
            if (sclRise) begin
              shift_r <= {shift_r[6:0], sdaIn};
              bitCnt_r <= bitCnt_r + 4'h1;
            end
            if (sclFall && bitCnt_r == 4'(sitpu_pkg::BIT_LAST + 1)) begin
              bitCnt_r <= 4'h0;
              if (state_r == sitpu_pkg::ST_ADDR) begin
                isRead_r <= shift_r[0];
                if (shift_r[7:1] == sitpu_pkg::TARGET_ADDR && timerReady) begin
                  sdaOut <= 1'b0;
                  sdaOe <= 1'b1;
                  state_r <= sitpu_pkg::ST_ACK;
                  word_r <= txWord;
                  byteIdx_r <= 2'h0;
                end else begin
                  state_r <= sitpu_pkg::ST_SKIP;
                end
              end else begin
                case (byteIdx_r)
                  2'h0: begin
                    word_r[15:8] <= shift_r;
                    crc_r <= crc8(sitpu_pkg::CRC_INIT, shift_r);
                    byteIdx_r <= 2'h1;
                  end
                  2'h1: begin
                    word_r[7:0] <= shift_r;
                    crc_r <= crc8(crc_r, shift_r);
                    // The first word is the 16-bit command.
                    if (!wordCount_r) begin
                      cmdCode_r <= {word_r[15:8], shift_r};
                      cmdValid_r <= 1'b1;
                      reinitReq_r <= ({word_r[15:8], shift_r} == sitpu_pkg::CMD_REINIT);
                      wordCount_r <= 1'b1;
                      byteIdx_r <= 2'h0;
                    end else begin
                      byteIdx_r <= 2'h2;
                    end
                  end
                  default: begin
                    crcError_r <= (shift_r != crc_r);
                    if (shift_r == crc_r) begin
                      argWord_r <= word_r;
                      argValid_r <= 1'b1;
                    end
                    byteIdx_r <= 2'h0;
                  end
                endcase
                sdaOut <= 1'b0;
                sdaOe <= 1'b1;
                state_r <= sitpu_pkg::ST_ACK;
              end
            end
          end
          sitpu_pkg::ST_ACK: begin
            // After the acknowledge clock, release SDA for a write, or drive the first data bit for a read.
            if (sclFall) begin
              if (isRead_r) begin
                state_r <= sitpu_pkg::ST_TX;
                shift_r <= word_r[15:8];
                crc_r <= crc8(sitpu_pkg::CRC_INIT, word_r[15:8]);
                sdaOut <= word_r[15];
                sdaOe <= !word_r[15];
                bitCnt_r <= 4'h1;
              end else begin
                sdaOe <= 1'b0;
                state_r <= sitpu_pkg::ST_RX;
              end
            end
          end
          sitpu_pkg::ST_TX: begin
            if (sclFall) begin
              if (bitCnt_r == 4'(sitpu_pkg::BIT_LAST + 1)) begin
                sdaOe <= 1'b0;
                state_r <= sitpu_pkg::ST_TXACK;
              end else begin
                sdaOut <= shift_r[3'(7 - bitCnt_r)];
                sdaOe <= !shift_r[3'(7 - bitCnt_r)];
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          sitpu_pkg::ST_TXACK: begin
            if (sclRise) begin
              ackBit_r <= sdaIn;
            end
            if (sclFall) begin
              if (ackBit_r) begin
                state_r <= sitpu_pkg::ST_SKIP;
              end else begin
                if (byteIdx_r == 2'h0) begin
                  crc_r <= crc8(crc_r, txNext);
                end else if (byteIdx_r == 2'h2) begin
                  crc_r <= crc8(sitpu_pkg::CRC_INIT, txNext);
                end
                byteIdx_r <= (byteIdx_r == 2'h2) ? 2'h0 : byteIdx_r + 2'h1;
                shift_r <= txNext;
                sdaOut <= txNext[7];
                sdaOe <= !txNext[7];
                bitCnt_r <= 4'h1;
                state_r <= sitpu_pkg::ST_TX;
              end
            end
          end
          sitpu_pkg::ST_SKIP: begin
            sdaOe <= 1'b0;
          end
          default: begin
            state_r <= sitpu_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // sitpu_target

// File: rtl/sitpu_wait_timer.sv
// Readiness timer: counts the power-up and re-initialization waits.
`timescale 1ns/10ps
module sitpu_wait_timer #(
  parameter logic [25:0] POWER_UP_CYCLES = 26'(sitpu_pkg::POWER_UP_CYC),
  parameter logic [25:0] REINIT_CYCLES = 26'(sitpu_pkg::REINIT_CYC)
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic startReinit,
  output logic ready
);
  logic [sitpu_pkg::WAIT_W-1:0] count_r;
  // Set by a re-initialization so that the soft reset wait uses its own length.
  logic reinitWait_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
      reinitWait_r <= 1'b0;
      ready <= 1'b0;
    end else if (startReinit) begin
      count_r <= '0;
      reinitWait_r <= 1'b1;
      ready <= 1'b0;
    end else if (!ready) begin
      count_r <= count_r + 26'h0000001;
      if (count_r + 26'h0000001 >= (reinitWait_r ? REINIT_CYCLES : POWER_UP_CYCLES)) begin
        ready <= 1'b1;
      end
    end
  end
endmodule // sitpu_wait_timer

// File: tb/sitpu_host.sv
// Bus controller model that pulls SCL and SDA low only, at 100 kHz.
`timescale 1ns/10ps
module sitpu_host (
  input wire logic core_clk,
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic sclLow = 1'b0;
  logic sdaLow = 1'b0;
  assign sclIn = !sclLow;
  assign sdaIn = !(sdaLow || sdaOe);
  task automatic lv(input logic [1:0] cs);
    sclLow = !cs[1];
    sdaLow = !cs[0];
    repeat (50) @(posedge core_clk);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    lv({1'b0, b});
    lv({1'b1, b});
    r = sdaIn;
    lv({1'b1, b});
    lv({1'b0, b});
  endtask
  task automatic start();
    lv({!sclLow, 1'b1});
    lv(2'h3);
    lv(2'h2);
    lv(2'h0);
  endtask
  task automatic stop();
    lv(2'h0);
    lv(2'h2);
    lv(2'h3);
  endtask
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rdByte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(last, r);
  endtask
endmodule // sitpu_host

// File: tb/sitpu_target_props.sv
// Port checker of the sensor I2C target, bound into the design.
`timescale 1ns/10ps
module sitpu_target_props #(
  parameter logic [25:0] POWER_UP_CYCLES = 26'h64,
  parameter logic [25:0] REINIT_CYCLES = 26'h64
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [15:0] txWord,
  input wire logic [15:0] cmdCode_r,
  input wire logic cmdValid_r,
  input wire logic [15:0] argWord_r,
  input wire logic argValid_r,
  input wire logic crcError_r,
  input wire logic ready_r,
  input wire logic busy_r
);
  localparam logic [25:0] LIM = (POWER_UP_CYCLES > REINIT_CYCLES ? POWER_UP_CYCLES : REINIT_CYCLES) + 26'h1;
  logic [25:0] lowCnt_r;
  // Counts how long the target has been unready, so that both waits can be bounded.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt_r <= 26'h0;
    end else begin
      lowCnt_r <= ready_r ? 26'h0 : lowCnt_r + 26'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_start; sclIn && $fell(sdaIn); endsequence
  sequence s_reinit; cmdValid_r && cmdCode_r == sitpu_pkg::CMD_REINIT; endsequence
  property p_odrain; sdaOe |-> !sdaOut; endproperty
  a_odrain: assert property (p_odrain) else $error("SDA driven high");
  property p_edge; $changed(sdaOe) |-> !sclIn; endproperty
  a_edge: assert property (p_edge) else $error("SDA moved with SCL high");
  property p_start; s_start |-> !sdaOe [*2]; endproperty
  a_start: assert property (p_start) else $error("SDA held at START");
  property p_nack; $rose(sdaOe) |-> ready_r; endproperty
  a_nack: assert property (p_nack) else $error("ACK while not ready");
  property p_busy; $past(resetn) |-> busy_r != ready_r; endproperty
  a_busy: assert property (p_busy) else $error("busy not inverse of ready");
  property p_wait; lowCnt_r <= LIM; endproperty
  a_wait: assert property (p_wait) else $error("ready wait too long");
  property p_reinit; s_reinit |-> ##[0:3] !ready_r; endproperty
  a_reinit: assert property (p_reinit) else $error("re-init did not drop ready");
  property p_crc; argValid_r |-> ##[0:1] !crcError_r; endproperty
  a_crc: assert property (p_crc) else $error("word valid with CRC error");
endmodule // sitpu_target_props
bind sitpu_target sitpu_target_props #(.POWER_UP_CYCLES(POWER_UP_CYCLES), .REINIT_CYCLES(REINIT_CYCLES))
  i_sitpu_target_props (.core_clk, .resetn, .sclIn, .sdaIn, .sdaOut, .sdaOe, .txWord, .cmdCode_r, .cmdValid_r,
  .argWord_r, .argValid_r, .crcError_r, .ready_r, .busy_r);

// File: tb/tb.sv
// Self-checking bench of the sensor I2C target.
`timescale 1ns/10ps
module tb;
  localparam logic [25:0] WAIT_CYC = 26'hBB8;
  typedef struct {logic [6:0] adr; logic [15:0] cmd; logic ack; logic [15:0] code;} sitpu_row_t;
  sitpu_row_t rows [4] = '{'{7'h62, 16'h21B1, 1'b1, 16'h21B1}, '{7'h63, 16'h3F86, 1'b0, 16'h21B1},
    '{7'h22, 16'h3F86, 1'b0, 16'h21B1}, '{7'h62, 16'hEC05, 1'b1, 16'hEC05}};
  logic [7:0] wr [9] = '{8'hC4, 8'h24, 8'h1D, 8'hBE, 8'hEF, 8'h92, 8'hBE, 8'hEF, 8'h93};
  logic [7:0] rd [4] = '{8'hBE, 8'hEF, 8'h92, 8'hBE};
  logic [7:0] ri [3] = '{8'hC4, 8'h36, 8'h46};
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] txWord = 16'hBEEF;
  logic sclIn, sdaIn, sdaOut, sdaOe, cmdValid_r, argValid_r, crcError_r, ready_r, busy_r, a;
  logic [15:0] cmdCode_r, argWord_r;
  logic [7:0] d;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  sitpu_target #(.POWER_UP_CYCLES(WAIT_CYC), .REINIT_CYCLES(WAIT_CYC)) i_sitpu_target (.core_clk, .resetn, .sclIn,
    .sdaIn, .sdaOut, .sdaOe, .txWord, .cmdCode_r, .cmdValid_r, .argWord_r, .argValid_r, .crcError_r, .ready_r, .busy_r);
  sitpu_host i_sitpu_host (.core_clk, .sdaOe, .sclIn, .sdaIn);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic probe(input logic exp);
    i_sitpu_host.start();
    i_sitpu_host.wrByte(8'hC4, a);
    chk(a, exp);
    i_sitpu_host.stop();
  endtask
  initial forever #25 core_clk = !core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    chk({ready_r, busy_r, sdaOe, cmdValid_r}, 16'h0);
    #1;
    resetn = 1'b1;
    fork
      probe(1'b0);
      begin
        repeat (WAIT_CYC) @(posedge core_clk);
        #1;
        chk(ready_r, 1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        chk(ready_r, 1'b1);
      end
    join
    foreach (rows[i]) begin
      i_sitpu_host.start();
      i_sitpu_host.wrByte({rows[i].adr, 1'b0}, a);
      chk(a, rows[i].ack);
      i_sitpu_host.wrByte(rows[i].cmd[15:8], a);
      i_sitpu_host.wrByte(rows[i].cmd[7:0], a);
      i_sitpu_host.stop();
      chk(cmdCode_r, rows[i].code);
    end
    i_sitpu_host.start();
    foreach (wr[i]) begin
      i_sitpu_host.wrByte(wr[i], a);
      if (i < 8) chk(a, 1'b1);
      if (i == 5) chk(crcError_r, 1'b0);
    end
    i_sitpu_host.stop();
    chk(argWord_r, 16'hBEEF);
    chk(crcError_r, 1'b1);
    repeat (20000) @(posedge core_clk);
    #1;
    i_sitpu_host.start();
    i_sitpu_host.wrByte(8'hC5, a);
    foreach (rd[i]) begin
      i_sitpu_host.rdByte(i == 3, d);
      chk(d, rd[i]);
    end
    i_sitpu_host.stop();
    i_sitpu_host.start();
    foreach (ri[i]) i_sitpu_host.wrByte(ri[i], a);
    i_sitpu_host.stop();
    chk(ready_r, 1'b0);
    probe(1'b0);
    repeat (3000) @(posedge core_clk);
    #1;
    chk(ready_r, 1'b1);
    probe(1'b1);
    end_of_test();
  end
endmodule // tb
